// ---- hw/scm_strap_top.sv ----
// Purpose: Latch configuration straps, apply them, mux shared pins
// Assumes: Straps are stable around reset release
// Notes:   Straps are caught at the first edge after reset release
//
// Functional notes
// [RULE_01] Codes 11000/11001: full advertisement, single/multi port
// [RULE_02] Codes 11010/11011: gigabit full duplex only
// [RULE_03] Code 11100 100 full/half, 11101 100 full
// [RULE_04] Code 11111: 100 and 10, no gigabit
// [RULE_05] Board avoids reserved mode codes
// [RULE_06] Gigabit half duplex is never advertised
// [RULE_07] Jack strap sets vendor bank 13h-1Eh defaults
// [RULE_08] Host interface strap: low parallel, high reduced
// [RULE_09] Five address straps set management address
// [RULE_10] Broadcast enable is inverse of its strap
// [RULE_11] Clock strap high drives local 125 MHz
// [RULE_12] LED style strap: high individual, low tri-colour
// [RULE_13] LED polarity is inverse of each strap
// [RULE_14] LED pins 1-5 become general pins 0-4
// [RULE_15] Collision/carrier pins become general pins 9/8; here only in reduced mode or half duplex
// [RULE_16] Transmit-error pin as pin 7 forces error off
// [RULE_17] Host sends no transmit errors in that case
// [RULE_18] Interrupt pin becomes general pin 5
// [RULE_19] Clock-output pin becomes general pin 6
// [RULE_20] Power event routes to selected enabled pins
// [RULE_21] Straps sampled once, held until next reset
`timescale 1ns/1ps
`include "scm_cfg.svh"

module scm_strap_top #(
  parameter logic [15:0] JACK_BANK_VAL = 16'h0001,
  parameter logic [15:0] STD_BANK_VAL  = 16'h0000
) (
  input  wire logic             mclk_i,
  input  wire logic             reset_n_i,
  input  wire logic [4:0]       mode_strap_i,
  input  wire logic             jack_compat_strap_i,
  input  wire logic             rgmii_strap_i,
  input  wire logic [4:0]       mgmt_addr_strap_i,
  input  wire logic             broadcast_addr_strap_i,
  input  wire logic             clk_out_enable_strap_i,
  input  wire logic             led_style_strap_i,
  input  wire logic [4:0]       led_polarity_straps_i,
  input  wire logic [7:0]       vb_index_i,
  input  wire logic [4:0]       led_on_i,
  input  wire logic             int_req_i,
  input  wire logic             crs_i,
  input  wire logic             col_i,
  input  wire logic             half_duplex_i,
  input  wire logic             power_event_i,
  input  wire logic [9:0]       gp_enable_i,
  input  wire logic [9:0]       gp_out_i,
  input  wire logic [9:0]       gp_oe_i,
  input  wire logic [4:0]       gp_data_select_one_i,
  input  wire logic [4:0]       gp_data_select_two_i,
  input  wire logic [9:0]       pin_in_i,
  output logic                  cfg_valid_o,
  output scm_pkg::scm_adv_t     adv_o,
  output logic                  mode_reserved_o,
  output logic                  rgmii_sel_o,
  output logic [4:0]            mgmt_addr_o,
  output logic                  bcast_en_o,
  output logic                  clk_out_en_o,
  output logic                  led_individual_o,
  output logic [4:0]            led_pol_o,
  output logic                  jack_compat_o,
  output logic [15:0]           bank_init_o,
  output logic                  tx_er_int_o,
  output logic [9:0]            pin_out_o,
  output logic [9:0]            pin_oe_o,
  output logic [9:0]            gp_in_o
);

  localparam logic [3:0] CLK_HALF = 4'(`SCM_CLK_HALF);

  scm_pkg::scm_state_t s_q;
  scm_pkg::scm_state_t s_d;
  scm_pkg::scm_adv_t   dec_adv;
  logic                dec_rsv;
  logic [9:0]          prim_out;
  logic [9:0]          prim_oe;
  logic [9:0]          en_eff;
  logic [9:0]          mux_out;
  logic [9:0]          mux_oe;
  logic [9:0]          mux_in;
  logic                run;

  // ----------------------------------------------------------------------
  // Mode decode and pin mux
  // ----------------------------------------------------------------------
  scm_mode_dec u_dec (
    .mode_i     (mode_strap_i),
    .adv_o      (dec_adv),
    .reserved_o (dec_rsv)
  );

  assign run = (s_q.phase == scm_pkg::SCM_ST_RUN);

  always_comb begin
    en_eff = gp_enable_i & {10{run}};
    en_eff[`SCM_GP_COL] = en_eff[`SCM_GP_COL] &
                          (s_q.cfg.rgmii | half_duplex_i); // RULE_15
    en_eff[`SCM_GP_CRS] = en_eff[`SCM_GP_CRS] &
                          (s_q.cfg.rgmii | half_duplex_i); // RULE_15
  end

  always_comb begin
    prim_out = '0;
    prim_oe  = '0;
    if (run) begin
      prim_out[4:0] = ~(led_on_i ^ s_q.cfg.led_pol); // RULE_13
      prim_oe[4:0]  = '1;
      prim_out[`SCM_GP_INT]  = 1'b0;
      prim_oe[`SCM_GP_INT]   = int_req_i; // RULE_18
      prim_out[`SCM_GP_CLK]  = s_q.ref_clk; // RULE_11
      prim_oe[`SCM_GP_CLK]   = s_q.cfg.clk_out_en; // RULE_11
      prim_out[`SCM_GP_CRS]  = crs_i;
      prim_oe[`SCM_GP_CRS]   = ~s_q.cfg.rgmii;
      prim_out[`SCM_GP_COL]  = col_i;
      prim_oe[`SCM_GP_COL]   = ~s_q.cfg.rgmii;
    end
  end

  scm_pin_mux #(
    .N (`SCM_GP_NUM)
  ) u_mux (
    .prim_out_i    (prim_out),
    .prim_oe_i     (prim_oe),
    .gp_en_i       (en_eff),
    .gp_out_i      (gp_out_i),
    .gp_oe_i       (gp_oe_i),
    .pme_sel_i     ({gp_data_select_two_i, gp_data_select_one_i}),
    .power_event_i (power_event_i),
    .pin_in_i      (pin_in_i),
    .pin_out_o     (mux_out),
    .pin_oe_o      (mux_oe),
    .gp_in_o       (mux_in)
  );

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    case (s_q.phase)
      scm_pkg::SCM_ST_LOAD: begin
        s_d.cfg.mode           = mode_strap_i; // RULE_21
        s_d.cfg.jack_compat    = jack_compat_strap_i; // RULE_07
        s_d.cfg.rgmii          = rgmii_strap_i; // RULE_08
        s_d.cfg.mgmt_addr      = mgmt_addr_strap_i; // RULE_09
        s_d.cfg.bcast_en       = ~broadcast_addr_strap_i; // RULE_10
        s_d.cfg.clk_out_en     = clk_out_enable_strap_i; // RULE_11
        s_d.cfg.led_individual = led_style_strap_i; // RULE_12
        s_d.cfg.led_pol        = ~led_polarity_straps_i; // RULE_13
        s_d.adv                = dec_adv;
        s_d.mode_rsv           = dec_rsv;
        s_d.phase              = scm_pkg::SCM_ST_RUN;
      end
      scm_pkg::SCM_ST_RUN: begin
        s_d.phase = scm_pkg::SCM_ST_RUN; // RULE_21
      end
      default: begin
        s_d.phase = scm_pkg::SCM_ST_LOAD;
      end
    endcase
    if (s_q.clk_cnt == CLK_HALF - 4'h1) begin
      s_d.clk_cnt = 4'h0;
      s_d.ref_clk = ~s_q.ref_clk; // RULE_11
    end else begin
      s_d.clk_cnt = s_q.clk_cnt + 4'h1;
    end
    s_d.pin_out = mux_out; // RULE_14
    s_d.pin_oe  = mux_oe; // RULE_19
    s_d.gp_in   = mux_in;
    s_d.tx_er   = run & ~s_q.cfg.rgmii & ~en_eff[`SCM_GP_TXER] &
                  pin_in_i[`SCM_GP_TXER]; // RULE_16
    if (vb_index_i >= `SCM_VB_FIRST && vb_index_i <= `SCM_VB_LAST) begin
      s_d.bank_data = s_q.cfg.jack_compat ? JACK_BANK_VAL
                                          : STD_BANK_VAL; // RULE_07
    end else begin
      s_d.bank_data = 16'h0000;
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign cfg_valid_o      = run;
  assign adv_o            = s_q.adv;
  assign mode_reserved_o  = s_q.mode_rsv;
  assign rgmii_sel_o      = s_q.cfg.rgmii;
  assign mgmt_addr_o      = s_q.cfg.mgmt_addr;
  assign bcast_en_o       = s_q.cfg.bcast_en;
  assign clk_out_en_o     = s_q.cfg.clk_out_en;
  assign led_individual_o = s_q.cfg.led_individual;
  assign led_pol_o        = s_q.cfg.led_pol;
  assign jack_compat_o    = s_q.cfg.jack_compat;
  assign bank_init_o      = s_q.bank_data;
  assign tx_er_int_o      = s_q.tx_er;
  assign pin_out_o        = s_q.pin_out;
  assign pin_oe_o         = s_q.pin_oe;
  assign gp_in_o          = s_q.gp_in;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  full_adv_a: assert property ( // RULE_01
    @(posedge mclk_i) disable iff (!reset_n_i)
    run && (s_q.cfg.mode[4:1] == 4'hc) |->
      adv_o.gig_fd && adv_o.fd10 && adv_o.hd10 && adv_o.cat5 &&
      adv_o.eee100 && (adv_o.multi_port == s_q.cfg.mode[0]))
    else $error("full advertisement mode decoded wrongly");

  gig_only_a: assert property ( // RULE_02
    @(posedge mclk_i) disable iff (!reset_n_i)
    run && (s_q.cfg.mode[4:1] == 4'hd) |->
      adv_o.gig_fd && !adv_o.fd100 && !adv_o.hd100 && !adv_o.fd10 &&
      !adv_o.hd10 && adv_o.pause && adv_o.amdix)
    else $error("gigabit-only mode advertises slower abilities");

  fast_only_a: assert property ( // RULE_03
    @(posedge mclk_i) disable iff (!reset_n_i)
    run && (s_q.cfg.mode[4:1] == 4'he) |->
      adv_o.fd100 && (adv_o.hd100 != s_q.cfg.mode[0]) &&
      !adv_o.gig_fd && !adv_o.fd10)
    else $error("100 Mbps mode decoded wrongly");

  no_gig_a: assert property ( // RULE_04
    @(posedge mclk_i) disable iff (!reset_n_i)
    run && (s_q.cfg.mode == `SCM_MODE_FH100_10) |->
      !adv_o.gig_fd && adv_o.fd10 && adv_o.hd100 && adv_o.cat5)
    else $error("mode 11111 decoded wrongly");

  strap_load_a: assert property ( // RULE_08
    @(posedge mclk_i) disable iff (!reset_n_i)
    $rose(cfg_valid_o) |->
      rgmii_sel_o == $past(rgmii_strap_i) &&
      mgmt_addr_o == $past(mgmt_addr_strap_i) &&
      bcast_en_o == !$past(broadcast_addr_strap_i) &&
      led_pol_o == ~$past(led_polarity_straps_i))
    else $error("straps not latched in register sense");

  strap_hold_a: assert property ( // RULE_21
    @(posedge mclk_i) disable iff (!reset_n_i)
    cfg_valid_o ##1 cfg_valid_o |->
      $stable(mgmt_addr_o) && $stable(rgmii_sel_o) && $stable(adv_o))
    else $error("latched configuration changed after load");

  txer_force_a: assert property ( // RULE_16
    @(posedge mclk_i) disable iff (!reset_n_i)
    run && gp_enable_i[`SCM_GP_TXER] |=> !tx_er_int_o)
    else $error("transmit error not forced off");

  ref_clk_a: assert property ( // RULE_11
    @(posedge mclk_i) disable iff (!reset_n_i)
    run && clk_out_en_o && !gp_enable_i[`SCM_GP_CLK] |=>
      pin_oe_o[`SCM_GP_CLK] &&
      pin_out_o[`SCM_GP_CLK] != $past(pin_out_o[`SCM_GP_CLK]))
    else $error("reference clock output not toggling");

  gp_route_a: assert property ( // RULE_14
    @(posedge mclk_i) disable iff (!reset_n_i)
    run && gp_enable_i[0] && !gp_data_select_one_i[0] |=>
      pin_out_o[0] == $past(gp_out_i[0]) && pin_oe_o[0] == $past(gp_oe_i[0]))
    else $error("general pin 0 not routed");

  pme_route_a: assert property ( // RULE_20
    @(posedge mclk_i) disable iff (!reset_n_i)
    run && gp_enable_i[`SCM_GP_INT] && gp_data_select_two_i[0] |=>
      pin_oe_o[`SCM_GP_INT] == $past(power_event_i) &&
      !pin_out_o[`SCM_GP_INT])
    else $error("power event not routed to general pin 5");

  bank_range_a: assert property ( // RULE_07
    @(posedge mclk_i) disable iff (!reset_n_i)
    (vb_index_i < `SCM_VB_FIRST) || (vb_index_i > `SCM_VB_LAST) |=>
      bank_init_o == 16'h0000)
    else $error("bank default outside its index range");

  led_drive_a: assert property ( // RULE_13
    @(posedge mclk_i) disable iff (!reset_n_i)
    run && !gp_enable_i[0] |=>
      pin_oe_o[0] && (pin_out_o[0] == ($past(led_on_i[0]) ~^ led_pol_o[0])))
    else $error("LED pin 0 polarity wrong");

  int_pin_a: assert property ( // RULE_18
    @(posedge mclk_i) disable iff (!reset_n_i)
    run && !gp_enable_i[`SCM_GP_INT] |=>
      !pin_out_o[`SCM_GP_INT] && pin_oe_o[`SCM_GP_INT] == $past(int_req_i))
    else $error("interrupt pin not driven low on request");

  clk_gp_a: assert property ( // RULE_19
    @(posedge mclk_i) disable iff (!reset_n_i)
    run && gp_enable_i[`SCM_GP_CLK] && !gp_data_select_two_i[1] |=>
      pin_out_o[`SCM_GP_CLK] == $past(gp_out_i[`SCM_GP_CLK]) &&
      pin_oe_o[`SCM_GP_CLK] == $past(gp_oe_i[`SCM_GP_CLK]))
    else $error("clock output pin not routed as general pin 6");

  col_crs_gate_a: assert property ( // RULE_15
    @(posedge mclk_i) disable iff (!reset_n_i)
    run && !rgmii_sel_o && !half_duplex_i |=> gp_in_o[9:8] == 2'h0)
    else $error("collision or carrier pin freed in full duplex");

endmodule : scm_strap_top

// ---- hw/scm_cfg.svh ----
// Purpose: Constants of the strap loader and pin mux
// Assumes: Included by bare name
// Notes:   Offsets, codes, pin indices and timing only
`ifndef SCM_CFG_SVH
`define SCM_CFG_SVH

// ----------------------------------------------------------------------
// Device mode codes
// ----------------------------------------------------------------------
`define SCM_MODE_ALL_S    5'h18
`define SCM_MODE_ALL_M    5'h19
`define SCM_MODE_GIG_S    5'h1a
`define SCM_MODE_GIG_M    5'h1b
`define SCM_MODE_FH100    5'h1c
`define SCM_MODE_F100     5'h1d
`define SCM_MODE_RSV_HI   5'h1e
`define SCM_MODE_FH100_10 5'h1f
`define SCM_MODE_RSV_0    5'h00
`define SCM_MODE_RSV_1    5'h01
`define SCM_MODE_RSV_F    5'h0f

// ----------------------------------------------------------------------
// Vendor register bank range set by the jack strap
// ----------------------------------------------------------------------
`define SCM_VB_FIRST      8'h13
`define SCM_VB_LAST       8'h1e

// ----------------------------------------------------------------------
// General-purpose pin indices
// ----------------------------------------------------------------------
`define SCM_GP_NUM        10
`define SCM_GP_LED_NUM    5
`define SCM_GP_INT        5
`define SCM_GP_CLK        6
`define SCM_GP_TXER       7
`define SCM_GP_CRS        8
`define SCM_GP_COL        9

// ----------------------------------------------------------------------
// Timing: reference clock output from the 250 MHz system clock
// ----------------------------------------------------------------------
`define SCM_SYS_CLK_MHZ   250
`define SCM_REF_CLK_MHZ   125
`define SCM_CLK_HALF      (`SCM_SYS_CLK_MHZ / (2 * `SCM_REF_CLK_MHZ))

`endif

// ---- hw/scm_pkg.sv ----
// Purpose: Types of the strap loader and pin mux
// Assumes: Constants come from scm_cfg.svh
// Notes:   Used as scm_pkg::name, never imported
package scm_pkg;

  // --------------------------------------------------------------------
  // Load phase
  // --------------------------------------------------------------------
  typedef enum logic [0:0] {
    SCM_ST_LOAD = 1'b0,
    SCM_ST_RUN  = 1'b1
  } scm_phase_t;

  // --------------------------------------------------------------------
  // Advertised abilities
  // --------------------------------------------------------------------
  typedef struct packed {
    logic gig_fd;
    logic multi_port;
    logic gig_eee;
    logic fd100;
    logic hd100;
    logic eee100;
    logic fd10;
    logic hd10;
    logic pause;
    logic cat5;
    logic amdix;
  } scm_adv_t;

  // --------------------------------------------------------------------
  // Latched configuration, already in register sense
  // --------------------------------------------------------------------
  typedef struct packed {
    logic [4:0] mode;
    logic       jack_compat;
    logic       rgmii;
    logic [4:0] mgmt_addr;
    logic       bcast_en;
    logic       clk_out_en;
    logic       led_individual;
    logic [4:0] led_pol;
  } scm_cfg_t;

  // --------------------------------------------------------------------
  // Complete state of the top module
  // --------------------------------------------------------------------
  typedef struct packed {
    scm_phase_t phase;
    scm_cfg_t   cfg;
    scm_adv_t   adv;
    logic       mode_rsv;
    logic [3:0] clk_cnt;
    logic       ref_clk;
    logic [9:0] pin_out;
    logic [9:0] pin_oe;
    logic [9:0] gp_in;
    logic       tx_er;
    logic [15:0] bank_data;
  } scm_state_t;

endpackage : scm_pkg

// ---- hw/scm_mode_dec.sv ----
// Purpose: Decode the device mode code into advertised abilities
// Assumes: Purely combinational; caller registers the result
// Notes:   Codes outside the decoded set advertise nothing
`timescale 1ns/1ps
`include "scm_cfg.svh"

module scm_mode_dec (
  input  wire logic [4:0]        mode_i,
  output scm_pkg::scm_adv_t      adv_o,
  output logic                   reserved_o
);

  // --------------------------------------------------------------------
  // Decode
  // --------------------------------------------------------------------
  always_comb begin
    adv_o      = '0; // RULE_06
    reserved_o = 1'b0;
    case (mode_i)
      `SCM_MODE_ALL_S, `SCM_MODE_ALL_M: begin
        adv_o            = '1; // RULE_01
        adv_o.multi_port = mode_i[0]; // RULE_01
      end
      `SCM_MODE_GIG_S, `SCM_MODE_GIG_M: begin
        adv_o.gig_fd     = 1'b1; // RULE_02
        adv_o.gig_eee    = 1'b1;
        adv_o.multi_port = mode_i[0]; // RULE_02
        adv_o.pause      = 1'b1;
        adv_o.amdix      = 1'b1;
      end
      `SCM_MODE_FH100, `SCM_MODE_F100: begin
        adv_o.fd100  = 1'b1; // RULE_03
        adv_o.hd100  = ~mode_i[0]; // RULE_03
        adv_o.eee100 = 1'b1;
        adv_o.pause  = 1'b1;
        adv_o.amdix  = 1'b1;
      end
      `SCM_MODE_FH100_10: begin
        adv_o        = '1; // RULE_04
        adv_o.gig_fd = 1'b0; // RULE_04
        adv_o.multi_port = 1'b0;
        adv_o.gig_eee    = 1'b0;
      end
      `SCM_MODE_RSV_0, `SCM_MODE_RSV_1, `SCM_MODE_RSV_F,
      `SCM_MODE_RSV_HI: begin
        reserved_o = 1'b1; // RULE_05
      end
      default: begin
        adv_o = '0;
      end
    endcase
  end

endmodule : scm_mode_dec

// ---- hw/scm_pin_mux.sv ----
// Purpose: Route general-purpose functions onto shared pins
// Assumes: Enables are already qualified by the caller
// Notes:   Power event is active high here, driven open-drain low
`timescale 1ns/1ps
`include "scm_cfg.svh"

module scm_pin_mux #(
  parameter int N = `SCM_GP_NUM
) (
  input  wire logic [N-1:0] prim_out_i,
  input  wire logic [N-1:0] prim_oe_i,
  input  wire logic [N-1:0] gp_en_i,
  input  wire logic [N-1:0] gp_out_i,
  input  wire logic [N-1:0] gp_oe_i,
  input  wire logic [N-1:0] pme_sel_i,
  input  wire logic         power_event_i,
  input  wire logic [N-1:0] pin_in_i,
  output logic [N-1:0]      pin_out_o,
  output logic [N-1:0]      pin_oe_o,
  output logic [N-1:0]      gp_in_o
);

  // --------------------------------------------------------------------
  // One slice per pin
  // --------------------------------------------------------------------
  for (genvar i = 0; i < N; i++) begin : g_pin
    always_comb begin
      if (gp_en_i[i] && pme_sel_i[i]) begin
        pin_out_o[i] = 1'b0; // RULE_20
        pin_oe_o[i]  = power_event_i; // RULE_20
      end else if (gp_en_i[i]) begin
        pin_out_o[i] = gp_out_i[i]; // RULE_14
        pin_oe_o[i]  = gp_oe_i[i];
      end else begin
        pin_out_o[i] = prim_out_i[i];
        pin_oe_o[i]  = prim_oe_i[i];
      end
      gp_in_o[i] = gp_en_i[i] & pin_in_i[i];
    end
  end

endmodule : scm_pin_mux

// ---- verif/scm_board_model.sv ----
// Purpose: Board straps and host side facing the strap block
// Assumes: Straps are held through reset and the load edge
// Notes:   Released straps show the inverse level after the load
`timescale 1ns/1ps

module scm_board_model (
  input  wire logic              mclk_i,
  input  wire logic              reset_n_i,
  input  wire logic              cfg_valid_i,
  input  wire scm_pkg::scm_cfg_t strap_i,
  input  wire logic [9:0]        pin_out_i,
  input  wire logic [9:0]        pin_oe_i,
  input  wire logic [9:0]        ext_pin_i,
  output scm_pkg::scm_cfg_t      strap_o,
  output logic [9:0]             pin_in_o
);
  // --------------------------------------------------------------------
  // Strap resistors
  // --------------------------------------------------------------------
  logic held_q;

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      held_q <= 1'b0;
    end else begin
      held_q <= cfg_valid_i;
    end
  end

  // Straps show the bench value until one cycle after cfg_valid_i rises, then invert
  assign strap_o = held_q ? ~strap_i : strap_i;

  // --------------------------------------------------------------------
  // Shared pins and host side
  // --------------------------------------------------------------------
  // Host drives its error line only where the bench asks for it
  assign pin_in_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & ext_pin_i);
endmodule : scm_board_model

// ---- verif/testbench.sv ----
// Purpose: Self-checking bench of the strap loader and pin mux
// Assumes: Inputs change at the falling edge of mclk_i
// Notes:   Pin outputs are checked one or two cycles after their inputs
`timescale 1ns/1ps
`include "scm_cfg.svh"

module testbench;
  localparam logic [15:0] JV = 16'h00a5;
  localparam logic [15:0] SV = 16'h005a;
  logic              mclk_i    = 1'b0;
  logic              reset_n_i = 1'b0;
  scm_pkg::scm_cfg_t st        = '0;
  scm_pkg::scm_cfg_t bs;
  scm_pkg::scm_cfg_t s;
  scm_pkg::scm_adv_t adv;
  logic [7:0]        vbi       = '0;
  logic [4:0]        led_on    = '0;
  logic [4:0]        sel1      = '0;
  logic [4:0]        sel2      = '0;
  logic              int_req   = 1'b0;
  logic              hd        = 1'b0;
  logic [1:0]        cc        = '0;
  logic              pev       = 1'b0;
  logic [9:0]        gen       = '0;
  logic [9:0]        gout      = '0;
  logic [9:0]        goe       = '0;
  logic [9:0]        ext       = '0;
  logic [9:0]        pin_in, pout, poe, gin;
  logic [4:0]        maddr, lpol;
  logic [15:0]       bank;
  logic              cv, rsv, rg, bc, ce, li, jc, txe, p6;
  int                n_mismatch = 0;
  int                cmp_count  = 0;
  int                cyc        = 0;
  logic [4:0]        codes [7]  = '{`SCM_MODE_ALL_S, `SCM_MODE_ALL_M,
    `SCM_MODE_GIG_S, `SCM_MODE_GIG_M, `SCM_MODE_FH100, `SCM_MODE_F100,
    `SCM_MODE_FH100_10};
  logic [10:0]       advs [7]   = '{11'h5ff, 11'h7ff, 11'h505, 11'h705,
    11'h0e5, 11'h0a5, 11'h0ff};
  logic [7:0]        idx [4]    = '{8'h12, 8'h13, 8'h1e, 8'h1f};

  // --------------------------------------------------------------------
  // Clock, design and partner
  // --------------------------------------------------------------------
  always #2 mclk_i = ~mclk_i;

  scm_strap_top #(.JACK_BANK_VAL(JV), .STD_BANK_VAL(SV)) dut (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .mode_strap_i(bs.mode),
    .jack_compat_strap_i(bs.jack_compat), .rgmii_strap_i(bs.rgmii),
    .mgmt_addr_strap_i(bs.mgmt_addr), .broadcast_addr_strap_i(bs.bcast_en),
    .clk_out_enable_strap_i(bs.clk_out_en),
    .led_style_strap_i(bs.led_individual),
    .led_polarity_straps_i(bs.led_pol), .vb_index_i(vbi),
    .led_on_i(led_on), .int_req_i(int_req), .crs_i(cc[0]), .col_i(cc[1]),
    .half_duplex_i(hd), .power_event_i(pev), .gp_enable_i(gen),
    .gp_out_i(gout), .gp_oe_i(goe), .gp_data_select_one_i(sel1),
    .gp_data_select_two_i(sel2), .pin_in_i(pin_in), .cfg_valid_o(cv),
    .adv_o(adv), .mode_reserved_o(rsv), .rgmii_sel_o(rg),
    .mgmt_addr_o(maddr), .bcast_en_o(bc), .clk_out_en_o(ce),
    .led_individual_o(li), .led_pol_o(lpol), .jack_compat_o(jc),
    .bank_init_o(bank), .tx_er_int_o(txe), .pin_out_o(pout),
    .pin_oe_o(poe), .gp_in_o(gin));

  scm_board_model board (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .cfg_valid_i(cv),
    .strap_i(st), .pin_out_i(pout), .pin_oe_i(poe), .ext_pin_i(ext),
    .strap_o(bs), .pin_in_o(pin_in));

  // --------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic load(input scm_pkg::scm_cfg_t c);
    reset_n_i = 1'b0;
    st = c;
    repeat (6) @(negedge mclk_i);
    reset_n_i = 1'b1;
    repeat (2) @(negedge mclk_i);
  endtask : load

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish

  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 2000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  // --------------------------------------------------------------------
  // Tests
  // --------------------------------------------------------------------
  initial begin
    s = '0;
    for (int i = 0; i < 7; i++) begin
      s.mode = codes[i];
      s.jack_compat = i[0];
      s.rgmii = i[1];
      s.mgmt_addr = 5'(i * 5 + 3);
      s.bcast_en = i[0];
      s.clk_out_en = ~i[1];
      s.led_individual = i[2];
      s.led_pol = 5'h15 ^ 5'(i);
      load(s);
      repeat (2) begin
        chk(16'(cv), 16'h0001, "valid");
        chk(16'(adv), 16'(advs[i]),
            "adv");
        chk(16'(rsv), 16'h0000, "reserved");
        chk(16'(rg), 16'(s.rgmii), "host if");
        chk(16'(maddr), 16'(s.mgmt_addr), "addr");
        chk(16'(bc), 16'({~s.bcast_en}), "bcast");
        chk(16'(ce), 16'(s.clk_out_en), "clk en");
        chk(16'(li), 16'(s.led_individual), "led style");
        chk(16'(lpol), 16'({~s.led_pol}), "led pol");
        chk(16'(jc), 16'(s.jack_compat), "jack");
        @(negedge mclk_i);
      end
    end
    $display("test straps done");
    for (int j = 0; j < 2; j++) begin
      s.jack_compat = j[0];
      load(s);
      for (int k = 0; k < 4; k++) begin
        vbi = idx[k];
        @(negedge mclk_i);
        chk(bank, (idx[k] >= `SCM_VB_FIRST && idx[k] <= `SCM_VB_LAST) ?
            (j[0] ? JV : SV) : 16'h0000, "bank");
      end
    end
    $display("test bank done");
    s.rgmii = 1'b0;
    s.clk_out_en = 1'b1;
    s.led_pol = 5'h0a;
    load(s);
    led_on = 5'h0f;
    int_req = 1'b1;
    cc = 2'h3;
    ext = 10'h3c5;
    @(negedge mclk_i);
    p6 = pout[6];
    chk(16'(pout[4:0]), 16'h0005, "led out");
    chk(16'(poe[6:5]), 16'h0003, "clk int oe");
    chk(16'(pout[5]), 16'h0000, "int low");
    chk(16'({poe[9:8], pout[9:8]}), 16'h000f, "col crs out");
    chk(16'(txe), 16'h0001, "tx err");
    @(negedge mclk_i);
    chk(16'(pout[6]), 16'({~p6}), "clk toggle");
    gen = 10'h0ff;
    gout = 10'h0aa;
    goe = 10'h0f0;
    repeat (2) @(negedge mclk_i);
    chk(16'(poe[7:0]), 16'h00f0, "gp oe");
    chk(16'(pout[7:4]), 16'h000a, "gp out");
    chk(16'(gin), 16'h00a5, "gp in");
    chk(16'(txe), 16'h0000, "tx err off");
    gen = 10'h3ff;
    sel1 = 5'h04;
    sel2 = 5'h11;
    pev = 1'b1;
    repeat (2) @(negedge mclk_i);
    chk(16'(gin[9:8]), 16'h0000, "col crs kept");
    chk(16'(poe[2]), 16'h0001, "pme oe");
    chk(16'(pout[2]), 16'h0000, "pme low");
    chk(16'(poe[5]), 16'h0001, "pme pin 5");
    hd = 1'b1;
    pev = 1'b0;
    repeat (2) @(negedge mclk_i);
    chk(16'(gin[9:8]), 16'h0003, "col crs half");
    chk(16'(poe[2]), 16'h0000, "pme off");
    hd = 1'b0;
    gen = 10'h300;
    s.rgmii = 1'b1;
    load(s);
    repeat (2) @(negedge mclk_i);
    chk(16'(gin[9:8]), 16'h0003, "col crs rgmii");
    chk(16'(txe), 16'h0000, "tx err rgmii");
    $display("test pins done");
    tally_and_finish();
  end
endmodule : testbench
